//--- bal_core.sv
// execution slice: add with file, and with file or literal, port direction load
// Overview of operation
// - a port operand is taken from the synchronised pin levels, never the latch
// - load-port-direction with 5, 6 or 7 copies accumulator into that port's latch
// - a one in a direction latch turns that pin's output buffer off
// - writing timer count register with destination file clears an assigned prescaler
// - destination bit zero writes accumulator, one writes the addressed file register
// - and-with-file ands accumulator with file, routes by destination, sets zero only
// - and-with-literal ands accumulator with literal into accumulator, sets zero only
`timescale 1ns/1ns
`include "bal_defines.svh"
module bal_core
  import bal_pkg::*;
  #(
  parameter int NUM_PORTS = 3
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic instrValid,
  input wire logic [11:0] instr,
  input wire logic [NUM_PORTS-1:0][7:0] pinIn,
  input wire logic [7:0] timerCount,
  input wire logic prescAssigned,
  output logic [7:0] accum_reg,
  output logic carry_reg,
  output logic digitCarry_reg,
  output logic zero_reg,
  output logic [NUM_PORTS-1:0][7:0] portOut_reg,
  output logic [NUM_PORTS-1:0][7:0] portOe_reg,
  output logic timerWrEn_reg,
  output logic [7:0] timerWrData_reg,
  output logic prescClr_reg
);
  localparam logic [4:0] PORT_LAST = 5'(`BAL_ADDR_PORT0 + NUM_PORTS - 1);

  generate
    if (NUM_PORTS < 1 || NUM_PORTS > 3)
    begin : g_bad_ports
      $error("bal_core: NUM_PORTS must be 1 to 3");
    end
  endgenerate

  function automatic logic isPortAddr(input logic [4:0] a);
    isPortAddr = (a >= `BAL_ADDR_PORT0) && (a <= PORT_LAST);
  endfunction : isPortAddr

  function automatic bal_op_t decodeOp(input logic [11:0] w);
    if (w[11:6] == `BAL_OPC6_ADD_FILE)
      decodeOp = BAL_OP_ADD_FILE;
    else if (w[11:6] == `BAL_OPC6_AND_FILE)
      decodeOp = BAL_OP_AND_FILE;
    else if (w[11:8] == `BAL_OPC4_AND_LIT)
      decodeOp = BAL_OP_AND_LIT;
    else if (w[11:3] == `BAL_DIRLOAD_HIGH && isPortAddr({2'b00, w[2:0]}))
      decodeOp = BAL_OP_DIR_LOAD;
    else
      decodeOp = BAL_OP_NONE;
  endfunction : decodeOp

  bal_alu_if aluBus ();
  bal_alu u_alu (
    .bus(aluBus.alu)
  );

  bal_op_t op;
  logic [4:0] fAddr;
  logic destFile;
  logic [1:0] portIdx;
  logic [1:0] dirIdx;
  logic fileOp;
  logic fileWrite;
  logic timerHit;
  logic prescHit;
  logic [7:0] operand;
  logic [7:0] gprMem [0:31];
  // unpacked so that each sync process owns its own element
  logic [7:0] pinStable_reg [NUM_PORTS];

  assign op = instrValid ? decodeOp(instr) : BAL_OP_NONE;
  assign fAddr = instr[4:0];
  assign destFile = instr[`BAL_D_BIT];
  assign portIdx = 2'(fAddr - `BAL_ADDR_PORT0);
  assign dirIdx = 2'({2'b00, instr[2:0]} - `BAL_ADDR_PORT0);
  assign fileOp = (op == BAL_OP_ADD_FILE) || (op == BAL_OP_AND_FILE);
  assign fileWrite = fileOp && destFile;
  assign timerHit = fileWrite && fAddr == `BAL_ADDR_TIMER;
  assign prescHit = timerHit && prescAssigned;

  // pins cross in through three flops; a bit moves once stages two and three agree
  generate
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_pin_sync
      logic [7:0] s1_reg;
      logic [7:0] s2_reg;
      logic [7:0] s3_reg;
      logic [7:0] agree;
      assign agree = ~(s2_reg ^ s3_reg);
      always_ff @(posedge mclk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          s1_reg <= 8'h00;
          s2_reg <= 8'h00;
          s3_reg <= 8'h00;
          pinStable_reg[p] <= 8'h00;
        end
        else
        begin
          s1_reg <= pinIn[p];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          pinStable_reg[p] <= (s3_reg & agree) | (pinStable_reg[p] & ~agree);
        end
      end
    end
  endgenerate

  // a port reads back its pins, so an input bit held low by the outside returns zero
  always_comb
  begin
    if (fAddr == `BAL_ADDR_TIMER)
      operand = timerCount;
    else if (isPortAddr(fAddr))
      operand = pinStable_reg[portIdx];
    else
      operand = gprMem[fAddr];
  end

  assign aluBus.opA = accum_reg;
  assign aluBus.opB = (op == BAL_OP_AND_LIT) ? instr[7:0] : operand;
  assign aluBus.func = (op == BAL_OP_ADD_FILE) ? BAL_ALU_ADD : BAL_ALU_AND;

  // accumulator and flags; and-type ops leave carry and digit carry alone
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      accum_reg <= `BAL_ACC_RST;
      carry_reg <= 1'b0;
      digitCarry_reg <= 1'b0;
      zero_reg <= 1'b0;
    end
    else
    begin
      if ((fileOp && !destFile) || op == BAL_OP_AND_LIT)
        accum_reg <= aluBus.result;
      if (fileOp || op == BAL_OP_AND_LIT)
        zero_reg <= aluBus.zero;
      if (op == BAL_OP_ADD_FILE)
      begin
        carry_reg <= aluBus.carry;
        digitCarry_reg <= aluBus.digitCarry;
      end
    end
  end

  // general file registers; the special addresses never land here
  always_ff @(posedge mclk)
  begin
    if (fileWrite && fAddr != `BAL_ADDR_TIMER && !isPortAddr(fAddr))
      gprMem[fAddr] <= aluBus.result;
  end

  // output latches and direction latches; enable is kept as its own flop
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < NUM_PORTS; i++)
      begin
        portOut_reg[i] <= `BAL_LATCH_RST;
        portOe_reg[i] <= ~`BAL_LOAD_PORT_DIRECTION_RST;
      end
    end
    else
    begin
      if (op == BAL_OP_DIR_LOAD)
        portOe_reg[dirIdx] <= ~accum_reg;
      if (fileWrite && isPortAddr(fAddr))
        portOut_reg[portIdx] <= aluBus.result;
    end
  end

  // timer write and prescaler clear, one cycle pulses
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      timerWrEn_reg <= 1'b0;
      timerWrData_reg <= 8'h00;
      prescClr_reg <= 1'b0;
    end
    else
    begin
      timerWrEn_reg <= timerHit;
      if (timerHit)
        timerWrData_reg <= aluBus.result;
      prescClr_reg <= prescHit;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  a_dir_load: assert property (
    op == BAL_OP_DIR_LOAD |=> portOe_reg[$past(dirIdx)] == ~$past(accum_reg))
    else $error("direction latch not loaded from accumulator");
  a_oe_hold: assert property (
    op == BAL_OP_NONE |=> portOe_reg == $past(portOe_reg))
    else $error("output enable moved without a direction load");
  a_and_lit_result: assert property (
    op == BAL_OP_AND_LIT |=> accum_reg == ($past(accum_reg) & $past(instr[7:0]))
      && zero_reg == (accum_reg == 8'h00))
    else $error("and with literal gave wrong accumulator or zero");
  a_and_flags_keep: assert property (
    op == BAL_OP_AND_FILE || op == BAL_OP_AND_LIT |=> $stable(carry_reg) && $stable(digitCarry_reg))
    else $error("and operation disturbed carry flags");
  a_and_file_result: assert property (
    op == BAL_OP_AND_FILE && !destFile |=> accum_reg == ($past(accum_reg) & $past(operand)))
    else $error("and with file wrong result in accumulator");
  a_add_result: assert property (
    op == BAL_OP_ADD_FILE && !destFile
      |=> {carry_reg, accum_reg} == {1'b0, $past(accum_reg)} + {1'b0, $past(operand)})
    else $error("add gave wrong sum or carry");
  a_dest_file: assert property (
    fileWrite |=> $stable(accum_reg))
    else $error("file destination changed accumulator");
  a_presc_clear: assert property (
    prescHit |=> prescClr_reg ##1 (!prescClr_reg || $past(prescHit)))
    else $error("prescaler clear not a single pulse after timer write");
  a_presc_cause: assert property (
    prescClr_reg |-> $past(fileWrite) && $past(destFile) && $past(prescAssigned) && timerWrEn_reg)
    else $error("prescaler cleared without a timer write");
  a_port_pins: assert property (
    fileWrite && fAddr == `BAL_ADDR_PORT0 && op == BAL_OP_AND_FILE
      |=> portOut_reg[0] == ($past(accum_reg) & $past(pinStable_reg[0])))
    else $error("port operand not taken from pins");

  c_add_carry: cover property (op == BAL_OP_ADD_FILE ##1 carry_reg && digitCarry_reg);
  c_dir_load: cover property (op == BAL_OP_DIR_LOAD ##1 op == BAL_OP_DIR_LOAD);
  c_presc_clear: cover property (prescClr_reg);
  c_and_lit_zero: cover property (op == BAL_OP_AND_LIT ##1 zero_reg);
endmodule : bal_core

//--- bal_defines.svh
// constants for the byte alu and port operations slice
`ifndef BAL_DEFINES_SVH
`define BAL_DEFINES_SVH
`define BAL_OPC6_ADD_FILE 6'h07
`define BAL_OPC6_AND_FILE 6'h05
`define BAL_OPC4_AND_LIT 4'hE
`define BAL_DIRLOAD_HIGH 9'h000
`define BAL_ADDR_TIMER 5'h01
`define BAL_ADDR_PORT0 5'h05
`define BAL_D_BIT 5
`define BAL_DIGIT_BIT 4
`define BAL_ACC_RST 8'h00
`define BAL_LOAD_PORT_DIRECTION_RST 8'hFF
`define BAL_LATCH_RST 8'h00
`endif

//--- bal_pkg.sv
// types shared by the byte alu and port operations slice
package bal_pkg;
  typedef enum logic [2:0] {
    BAL_OP_NONE  = 3'b000,
    BAL_OP_ADD_FILE = 3'b001,
    BAL_OP_AND_FILE = 3'b010,
    BAL_OP_AND_LIT = 3'b011,
    BAL_OP_DIR_LOAD = 3'b100
  } bal_op_t;
  typedef enum logic {
    BAL_ALU_ADD = 1'b0,
    BAL_ALU_AND = 1'b1
  } bal_alu_t;
endpackage : bal_pkg

//--- bal_alu_if.sv
// operand and result bundle between the core and its alu
`timescale 1ns/1ns
interface bal_alu_if
  import bal_pkg::*;
  ();
  logic [7:0] opA;
  logic [7:0] opB;
  bal_alu_t func;
  logic [7:0] result;
  logic carry;
  logic digitCarry;
  logic zero;
  modport core (output opA, output opB, output func, input result, input carry,
    input digitCarry, input zero);
  modport alu (input opA, input opB, input func, output result, output carry,
    output digitCarry, output zero);
endinterface : bal_alu_if

//--- bal_alu.sv
// combinational add and and unit with flag generation
`timescale 1ns/1ns
`include "bal_defines.svh"
module bal_alu
  import bal_pkg::*;
  (
  bal_alu_if.alu bus
);
  logic [8:0] sum;
  logic [4:0] lowSum;

  always_comb
  begin
    sum = {1'b0, bus.opA} + {1'b0, bus.opB};
    lowSum = {1'b0, bus.opA[3:0]} + {1'b0, bus.opB[3:0]};
    unique case (bus.func)
      BAL_ALU_ADD:
      begin
        bus.result = sum[7:0];
      end
      BAL_ALU_AND:
      begin
        bus.result = bus.opA & bus.opB;
      end
    endcase
    bus.carry = sum[8];
    bus.digitCarry = lowSum[`BAL_DIGIT_BIT];
    bus.zero = (bus.result == 8'h00);
  end
endmodule : bal_alu

//--- bal_pin_model.sv
// outside devices on the port pins, resolved against the core's own drivers
`timescale 1ns/1ns
module bal_pin_model
  #(
  parameter int NUM_PORTS = 3
) (
  input wire logic [NUM_PORTS-1:0][7:0] outData,
  input wire logic [NUM_PORTS-1:0][7:0] outEnable,
  input wire logic [NUM_PORTS-1:0][7:0] extLevel,
  output logic [NUM_PORTS-1:0][7:0] pinIn
);
  // a pin whose buffer is off shows only the outside level, so latch and pin can differ
  always_comb
  begin
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      pinIn[p] = (outEnable[p] & outData[p]) | (~outEnable[p] & extLevel[p]);
    end
  end
endmodule : bal_pin_model

//--- byte_alu_and_port_ops_tb.sv
// self-checking bench for the byte alu and port operations slice
`timescale 1ns/1ns
module byte_alu_and_port_ops_tb;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic instrValid = 1'b0;
  logic [11:0] instr = 12'h000;
  logic [7:0] timerCount = 8'h00;
  logic prescAssigned = 1'b0;
  logic [2:0][7:0] extLevel = {3{8'h00}};
  logic [2:0][7:0] pinIn;
  logic [7:0] accum_reg;
  logic carry_reg;
  logic digitCarry_reg;
  logic zero_reg;
  logic [2:0][7:0] portOut_reg;
  logic [2:0][7:0] portOe_reg;
  logic timerWrEn_reg;
  logic [7:0] timerWrData_reg;
  logic prescClr_reg;
  int fail_count = 0;
  int check_count = 0;
  int cycleCount = 0;
  always #25 mclk = ~mclk;
  bal_core #(.NUM_PORTS(3)) dut_u (.mclk(mclk), .arst_n(arst_n), .instrValid(instrValid),
    .instr(instr), .pinIn(pinIn), .timerCount(timerCount), .prescAssigned(prescAssigned),
    .accum_reg(accum_reg), .carry_reg(carry_reg), .digitCarry_reg(digitCarry_reg),
    .zero_reg(zero_reg), .portOut_reg(portOut_reg), .portOe_reg(portOe_reg),
    .timerWrEn_reg(timerWrEn_reg), .timerWrData_reg(timerWrData_reg),
    .prescClr_reg(prescClr_reg));
  bal_pin_model #(.NUM_PORTS(3)) pins_u (.outData(portOut_reg), .outEnable(portOe_reg),
    .extLevel(extLevel), .pinIn(pinIn));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // valid stays high between back-to-back words; idle drops it
  task automatic exec(input logic [11:0] word);
    instrValid = 1'b1;
    instr = word;
    @(negedge mclk);
  endtask : exec
  task automatic idle(input int n);
    instrValid = 1'b0;
    repeat (n) @(negedge mclk);
  endtask : idle
  task automatic flags(input logic [2:0] exp);
    check("flags", {carry_reg, digitCarry_reg, zero_reg}, exp);
  endtask : flags
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  // generous ceiling: the sequence needs well under a hundred cycles
  always @(posedge mclk)
  begin
    cycleCount++;
    if (cycleCount == 2000)
    begin
      fail_count++;
      test_done();
    end
  end
  initial
  begin
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    check("accum", accum_reg, 16'h0000);
    check("portOeHi", portOe_reg[2:1], 16'h0000);
    check("portOeLo", portOe_reg[0], 16'h0000);
    extLevel[0] = 8'hF0;
    idle(5);
    exec(12'h1C5);
    check("accum", accum_reg, 16'h00F0);
    flags(3'h0);
    timerCount = 8'h1F;
    exec(12'h1C1);
    check("accum", accum_reg, 16'h000F);
    flags(3'h4);
    timerCount = 8'h09;
    exec(12'h1C1);
    check("accum", accum_reg, 16'h0018);
    flags(3'h2);
    $display("add test done");
    exec(12'hE5F);
    check("accum", accum_reg, 16'h0018);
    flags(3'h2);
    exec(12'hE07);
    check("accum", accum_reg, 16'h0000);
    flags(3'h3);
    $display("literal and test done");
    exec(12'h1C5);
    for (int p = 0; p < 3; p++)
    begin
      exec(12'h005 + 12'(p));
      check("portOe", portOe_reg[p], 16'h000F);
    end
    exec(12'h004);
    check("portOeAll", portOe_reg[2:1], 16'h0F0F);
    check("portOeLo", portOe_reg[0], 16'h000F);
    extLevel[0] = 8'h30;
    idle(5);
    exec(12'h165);
    check("portOut", portOut_reg[0], 16'h0030);
    check("accum", accum_reg, 16'h00F0);
    $display("port test done");
    timerCount = 8'h17;
    prescAssigned = 1'b1;
    exec(12'h161);
    check("timerWr", {timerWrEn_reg, prescClr_reg, timerWrData_reg}, 16'h0310);
    check("accumKept", accum_reg, 16'h00F0);
    exec(12'h141);
    check("timerWr", {timerWrEn_reg, prescClr_reg}, 16'h0000);
    check("accum", accum_reg, 16'h0010);
    prescAssigned = 1'b0;
    exec(12'h161);
    check("timerWr", {timerWrEn_reg, prescClr_reg, timerWrData_reg}, 16'h0210);
    idle(1);
    $display("timer test done");
    arst_n = 1'b0;
    repeat (2) @(negedge mclk);
    check("rstState", {accum_reg, portOut_reg[0]}, 16'h0000);
    check("rstOe", portOe_reg[2:1], 16'h0000);
    flags(3'h0);
    arst_n = 1'b1;
    exec(12'h168);
    flags(3'h1);
    timerCount = 8'h9C;
    exec(12'h1C1);
    check("accum", accum_reg, 16'h009C);
    exec(12'h1E8);
    check("accumKept", accum_reg, 16'h009C);
    exec(12'h1C8);
    check("accum", accum_reg, 16'h0038);
    flags(3'h6);
    idle(1);
    $display("file register test done");
    test_done();
  end
endmodule : byte_alu_and_port_ops_tb
